/* core/icc_pkg.sv */
`default_nettype none
package icc_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_LINE_INTERVAL = 10'h007;
   localparam logic [9:0] IDX_WIN_BEGIN = 10'h008;
   localparam logic [9:0] IDX_WIN_FINISH = 10'h009;
   localparam logic [9:0] IDX_MODE_FIRST = 10'h010;
   localparam logic [9:0] IDX_MODE_SECOND = 10'h011;
   localparam logic [9:0] IDX_SAMPLING = 10'h012;
   localparam logic [9:0] IDX_LEVEL = 10'h013;
   localparam logic [9:0] IDX_CLAMP_END = 10'h014;
   localparam logic [9:0] IDX_STATUS = 10'h015;
   localparam logic [9:0] IDX_WIN_ENABLE = 10'h18f;
   // field positions
   localparam int WIN_ENABLE_BIT = 1;
   localparam int AUTO_DIS_BIT = 4;
   localparam int DAC_SEL_LSB = 8;
   localparam int ST_WIN_BIT = 0;
   localparam int ST_ERR_LSB = 1;
   localparam int ST_PIN_BIT = 5;
   // mode and level codes
   localparam logic [1:0] MODE_PIXEL = 2'h0;
   localparam logic [1:0] MODE_LINE = 2'h1;
   localparam logic [1:0] MODE_UNCL_INT = 2'h2;
   localparam logic [1:0] MODE_UNCL_EXT = 2'h3;
   localparam logic [1:0] LEVEL_EXT_PIN = 2'h2;
   // reset values
   localparam logic [15:0] LINE_INTERVAL_COUNT_RST = 16'h0fff;
   localparam logic [15:0] WIN_BEGIN_RST = 16'h0000;
   localparam logic [15:0] WIN_FINISH_RST = 16'h0000;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] LEVEL_RST = 8'h00;
   localparam logic [1:0] DAC_SEL_RST = 2'h0;
   localparam logic [7:0] CLAMP_END_RST = 8'h04;
endpackage : icc_pkg
`default_nettype wire

/* core/icc_top.sv */
// The address-and-strobe port was decided locally.
`default_nettype none
module icc_top
   import icc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [11:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic ref_sample_a,
   input wire logic ref_sample_b,
   input wire logic clamp_reference_pin_in,
   output logic clamp_reference_pin_out,
   output logic clamp_reference_pin_oe,
   output logic [1:0] ref_dac_voltage_select,
   output logic [7:0] clamp_level_select,
   output logic [3:0] clamp_switch,
   output logic [3:0] sh_internal_black_ref_enable,
   output logic [3:0] channel_ground_ref_select,
   output logic clamp_pulse_group_a,
   output logic clamp_pulse_group_b,
   output logic line_cycle_pulse,
   output logic line_clamp_window
);

   typedef struct packed {
      logic [15:0] line_interval_count;
      logic [15:0] win_begin;
      logic [15:0] win_finish;
      logic [7:0] mode;
      logic win_en;
      logic [3:0] samp;
      logic auto_dis;
      logic [1:0] dac;
      logic [7:0] lvl;
      logic [15:0] cend;
      logic [15:0] line_cnt;
      logic ls;
      logic [15:0] pix_cnt;
      logic win;
      logic [1:0] shp_d;
      logic [15:0] hi_cnt;
      logic [15:0] wid;
      logic [15:0] age;
      logic [1:0] clp;
      logic [3:0] sw;
      logic [3:0] err;
      logic pin_oe;
      logic [2:0] pin_s;
      logic pin;
      logic [15:0] rdata;
   } icc_state_t;

   icc_state_t r;
   icc_state_t n;

   logic [9:0] idx;
   logic hit;
   logic [1:0] shp;
   logic [7:0] limit;
   logic [7:0] half;
   logic [1:0] md;
   logic grp;

   assign idx = reg_addr[11:2];
   assign hit = reg_addr[1:0] == 2'h0;
   assign shp = {ref_sample_b, ref_sample_a};

   always_comb begin
      n = r;
      limit = 8'h00;
      half = 8'h00;
      md = 2'h0;
      grp = 1'b0;
      // register writes
      if (reg_wr && hit) begin
         unique case (idx)
            IDX_LINE_INTERVAL: n.line_interval_count = reg_wdata;
            IDX_WIN_BEGIN: n.win_begin = reg_wdata;
            IDX_WIN_FINISH: n.win_finish = reg_wdata;
            IDX_MODE_FIRST: n.mode[3:0] = reg_wdata[3:0];
            IDX_MODE_SECOND: n.mode[7:4] = reg_wdata[3:0];
            IDX_SAMPLING: begin
               n.samp = reg_wdata[3:0];
               n.auto_dis = reg_wdata[AUTO_DIS_BIT];
               n.dac = reg_wdata[DAC_SEL_LSB +: 2];
            end
            IDX_LEVEL: n.lvl = reg_wdata[7:0];
            IDX_CLAMP_END: n.cend = reg_wdata;
            IDX_WIN_ENABLE: n.win_en = reg_wdata[WIN_ENABLE_BIT];
            default: ;
         endcase
      end
      // register reads, data valid the cycle after the strobe
      n.rdata = 16'h0000;
      if (reg_rd && hit) begin
         unique case (idx)
            IDX_LINE_INTERVAL: n.rdata = r.line_interval_count;
            IDX_WIN_BEGIN: n.rdata = r.win_begin;
            IDX_WIN_FINISH: n.rdata = r.win_finish;
            IDX_MODE_FIRST: n.rdata = {12'h000, r.mode[3:0]};
            IDX_MODE_SECOND: n.rdata = {12'h000, r.mode[7:4]};
            IDX_SAMPLING: n.rdata = {6'h00, r.dac, 3'h0, r.auto_dis, r.samp};
            IDX_LEVEL: n.rdata = {8'h00, r.lvl};
            IDX_CLAMP_END: n.rdata = r.cend;
            IDX_STATUS: n.rdata = {10'h000, r.pin, r.err, r.win};
            IDX_WIN_ENABLE: n.rdata = {14'h0000, r.win_en, 1'b0};
            default: n.rdata = 16'h0000;
         endcase
      end
      // internal line cycle: one-cycle pulse every line_interval_count+1 clocks
      if (r.line_cnt >= r.line_interval_count) begin
         n.line_cnt = 16'h0000;
         n.ls = 1'b1;
      end else begin
         n.line_cnt = r.line_cnt + 16'h0001;
         n.ls = 1'b0;
      end
      // pixel count restarts at the pulse falling edge; saturates on long lines
      if (r.ls) begin
         n.pix_cnt = 16'h0000;
      end else if (r.pix_cnt != 16'hffff) begin
         n.pix_cnt = r.pix_cnt + 16'h0001;
      end
      // window forced high until software enables it
      if (!n.win_en) begin
         n.win = 1'b1;
      end else begin
         n.win = (n.pix_cnt >= n.win_begin) && (n.pix_cnt < n.win_finish);
      end
      // per-group clamp pulse generation
      n.shp_d = shp;
      for (int g = 0; g < 2; g++) begin
         if (shp[g] && !r.shp_d[g]) begin
            n.hi_cnt[8*g +: 8] = 8'h01;
         end else if (shp[g] && r.hi_cnt[8*g +: 8] != 8'hff) begin
            n.hi_cnt[8*g +: 8] = r.hi_cnt[8*g +: 8] + 8'h01;
         end
         // width of the last complete sample pulse
         if (!shp[g] && r.shp_d[g]) begin
            n.wid[8*g +: 8] = r.hi_cnt[8*g +: 8];
         end
         half = {1'b0, r.wid[8*g+1 +: 7]};
         if (half == 8'h00) begin
            half = 8'h01;
         end
         limit = r.auto_dis ? r.cend[8*g +: 8] : half;
         if (shp[g] && !r.shp_d[g]) begin
            n.clp[g] = 1'b1;
            n.age[8*g +: 8] = 8'h01;
         end else if (r.clp[g]) begin
            if (r.age[8*g +: 8] >= limit) begin
               n.clp[g] = 1'b0;
            end else begin
               n.age[8*g +: 8] = r.age[8*g +: 8] + 8'h01;
            end
         end
      end
      // per-channel switch control; channel pairs share a group
      for (int c = 0; c < 4; c++) begin
         md = n.mode[2*c +: 2];
         grp = c[1];
         n.err[c] = ((md == MODE_LINE) && n.samp[c])
            || ((md[1]) && !n.samp[c]);
         unique case (md)
            MODE_PIXEL: n.sw[c] = n.win ? n.shp_d[grp] : n.clp[grp];
            // line clamp on sample-hold would droop badly, so it stays open
            MODE_LINE: n.sw[c] = !n.samp[c] && n.win && n.shp_d[grp];
            default: n.sw[c] = 1'b0;
         endcase
      end
      // reference pin: sensed when any channel selects it, else driven low
      n.pin_oe = 1'b1;
      for (int c = 0; c < 4; c++) begin
         if (n.lvl[2*c +: 2] == LEVEL_EXT_PIN) begin
            n.pin_oe = 1'b0;
         end
      end
      n.pin_s = {r.pin_s[1:0], clamp_reference_pin_in};
      if (r.pin_s[1] == r.pin_s[2]) begin
         n.pin = r.pin_s[2];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
         r.line_interval_count <= LINE_INTERVAL_COUNT_RST;
         r.win_begin <= WIN_BEGIN_RST;
         r.win_finish <= WIN_FINISH_RST;
         r.mode <= MODE_RST;
         r.lvl <= LEVEL_RST;
         r.dac <= DAC_SEL_RST;
         r.cend <= {CLAMP_END_RST, CLAMP_END_RST};
         r.win <= 1'b1;
         r.pin_oe <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata = r.rdata;
   assign clamp_switch = r.sw;
   assign clamp_pulse_group_a = r.clp[0];
   assign clamp_pulse_group_b = r.clp[1];
   assign line_cycle_pulse = r.ls;
   assign line_clamp_window = r.win;
   assign ref_dac_voltage_select = r.dac;
   assign clamp_level_select = r.lvl;
   assign clamp_reference_pin_out = 1'b0;
   assign clamp_reference_pin_oe = r.pin_oe;
   // static decode of the mode registers
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         sh_internal_black_ref_enable[c] = r.mode[2*c +: 2] == MODE_UNCL_INT;
         channel_ground_ref_select[c] = r.mode[2*c +: 2] == MODE_UNCL_EXT;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   property p_line_pulse_one;
      r.ls && r.line_interval_count != 16'h0000 |=> !r.ls;
   endproperty
   a_line_pulse_one: assert property (p_line_pulse_one)
      else $error("line pulse longer than one cycle");

   property p_uncl_off;
      r.mode[1] |-> !r.sw[0];
   endproperty
   a_uncl_off: assert property (p_uncl_off)
      else $error("unclamped channel 1 switch active");

   property p_win_default;
      !r.win_en |-> r.win;
   endproperty
   a_win_default: assert property (p_win_default)
      else $error("window low while disabled");

   property p_clamp_start;
      $rose(ref_sample_a) |=> clamp_pulse_group_a;
   endproperty
   a_clamp_start: assert property (p_clamp_start)
      else $error("clamp pulse a did not start");

   property p_pixel_window;
      r.mode[5:4] == MODE_PIXEL && r.win && r.shp_d[1] |-> r.sw[2];
   endproperty
   a_pixel_window: assert property (p_pixel_window)
      else $error("pixel clamp ignored window");

   property p_line_on_sh;
      r.mode[5:4] == MODE_LINE && r.samp[2] |-> !r.sw[2] && r.err[2];
   endproperty
   a_line_on_sh: assert property (p_line_on_sh)
      else $error("line clamp active on sample-hold");

   property p_win_enable_write;
      reg_wr && hit && idx == IDX_WIN_ENABLE |=> r.win_en == $past(reg_wdata[1]);
   endproperty
   a_win_enable_write: assert property (p_win_enable_write)
      else $error("window enable not stored");

   property p_group_b;
      r.mode[5:4] == MODE_PIXEL && !r.win |-> r.sw[2] == clamp_pulse_group_b;
   endproperty
   a_group_b: assert property (p_group_b)
      else $error("channel 3 not on group b");

   property p_manual_end;
      $rose(r.clp[0]) && r.auto_dis && r.cend[7:0] == 8'h03 && !r.shp_d[0] == 1'b0
         ##1 ref_sample_a[*2] |-> r.clp[0] ##1 !r.clp[0];
   endproperty
   a_manual_end: assert property (p_manual_end)
      else $error("manual clamp end wrong");

   property p_uncl_ch2;
      r.mode[3] |-> !r.sw[1];
   endproperty
   a_uncl_ch2: assert property (p_uncl_ch2)
      else $error("unclamped channel 2 switch active");

   property p_ref_enable;
      r.mode[1:0] == MODE_UNCL_INT |-> sh_internal_black_ref_enable[0]
         && !channel_ground_ref_select[0];
   endproperty
   a_ref_enable: assert property (p_ref_enable)
      else $error("internal black reference not enabled");

   property p_ground_select;
      r.mode[3:2] == MODE_UNCL_EXT |-> channel_ground_ref_select[1]
         && !sh_internal_black_ref_enable[1];
   endproperty
   a_ground_select: assert property (p_ground_select)
      else $error("external ground reference not selected");

   property p_line_window;
      r.mode[5:4] == MODE_LINE && !r.samp[2] |-> r.sw[2] == (r.win && r.shp_d[1]);
   endproperty
   a_line_window: assert property (p_line_window)
      else $error("line clamp outside window");

   property p_window_span;
      r.win_en |-> r.win == (r.pix_cnt >= r.win_begin && r.pix_cnt < r.win_finish);
   endproperty
   a_window_span: assert property (p_window_span)
      else $error("window edges wrong");

   property p_pix_restart;
      r.ls |=> r.pix_cnt == 16'h0000;
   endproperty
   a_pix_restart: assert property (p_pix_restart)
      else $error("pixel count not restarted");

   property p_level_pin;
      r.lvl[1:0] == LEVEL_EXT_PIN |-> !clamp_reference_pin_oe;
   endproperty
   a_level_pin: assert property (p_level_pin)
      else $error("reference pin driven while sensed");

   property p_dac_write;
      reg_wr && hit && idx == IDX_SAMPLING
         |=> ref_dac_voltage_select == $past(reg_wdata[DAC_SEL_LSB +: 2]);
   endproperty
   a_dac_write: assert property (p_dac_write)
      else $error("dac select not stored");

   property p_level_write;
      reg_wr && hit && idx == IDX_LEVEL |=> clamp_level_select == $past(reg_wdata[7:0]);
   endproperty
   a_level_write: assert property (p_level_write)
      else $error("level select not stored");

   property p_mode_write;
      reg_wr && hit && idx == IDX_MODE_FIRST |=> r.mode[3:0] == $past(reg_wdata[3:0]);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("clamp mode not stored");

   property p_group_a;
      r.mode[1:0] == MODE_PIXEL && !r.win |-> r.sw[0] == clamp_pulse_group_a;
   endproperty
   a_group_a: assert property (p_group_a)
      else $error("channel 1 not on group a");

   property p_clamp_start_b;
      $rose(ref_sample_b) |=> clamp_pulse_group_b;
   endproperty
   a_clamp_start_b: assert property (p_clamp_start_b)
      else $error("clamp pulse b did not start");

   property p_read_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data without strobe");

   property p_line_sh_flag;
      r.mode[5:4] == MODE_LINE |-> r.err[2] == r.samp[2];
   endproperty
   a_line_sh_flag: assert property (p_line_sh_flag)
      else $error("sampling mode check wrong");

endmodule : icc_top
`default_nettype wire

/* dv/icc_sensor_model.sv */
`default_nettype none
module icc_sensor_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [3:0] width,
   output logic ref_sample_a,
   output logic ref_sample_b,
   output logic ext_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r;
   logic [3:0] cnt_b;
   // group b lags by eight clocks, half the sample period, so the two groups never look alike
   assign cnt_b = cnt_r - 4'h8;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   assign ref_sample_a = (cnt_r < width);
   assign ref_sample_b = (cnt_b < width);
   // pin pulled up outside, seen high once the device lets go
   assign ext_level = 1'b1;
endmodule : icc_sensor_model
`default_nettype wire

/* dv/icc_top_tb.sv */
`default_nettype none
module icc_top_tb
   import icc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
   logic ref_a, ref_b, pin_in, pin_out, pin_oe, ext_level, cpa, cpb, lcp, win;
   logic [1:0] dac_sel;
   logic [7:0] lvl_sel;
   logic [3:0] sw, sh_en, gnd_sel;
   int num_errors = 0, checks_done = 0, c;
   // wire level: device drive wins when enabled, else the outside pull
   assign pin_in = pin_oe ? pin_out : ext_level;
   always #4 sys_clk = ~sys_clk;
   icc_top icc_top_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ref_sample_a(ref_a), .ref_sample_b(ref_b), .clamp_reference_pin_in(pin_in),
      .clamp_reference_pin_out(pin_out), .clamp_reference_pin_oe(pin_oe),
      .ref_dac_voltage_select(dac_sel), .clamp_level_select(lvl_sel), .clamp_switch(sw),
      .sh_internal_black_ref_enable(sh_en), .channel_ground_ref_select(gnd_sel),
      .clamp_pulse_group_a(cpa), .clamp_pulse_group_b(cpb), .line_cycle_pulse(lcp),
      .line_clamp_window(win));
   icc_sensor_model icc_sensor_model_i (.sys_clk(sys_clk), .rstn(rstn), .width(4'h4),
      .ref_sample_a(ref_a), .ref_sample_b(ref_b), .ext_level(ext_level));
   task automatic give_verdict();
      if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [9:0] idx, input logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= {idx, 2'b00};
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [9:0] idx, output logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= {idx, 2'b00};
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // counts high cycles of one output, or of sw[1:0] ORed by default; sel picks which
   task automatic cnt(input int sel, input int n, output int k);
      logic b;
      k = 0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         case (sel)
            0: b = cpa;
            1: b = cpb;
            2: b = win;
            3: b = lcp;
            5: b = sw[2];
            6: b = sw[3];
            default: b = |sw[1:0];
         endcase
         // an unknown level spoils the count so it can never pass
         if (b === 1'b1) k++;
         else if (b !== 1'b0) k += 256;
      end
   endtask : cnt
   task automatic wait_rise_a();
      logic p;
      int i;
      p = 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge sys_clk);
         #1;
         if (ref_a && !p) return;
         p = ref_a;
      end
      num_errors++;
      $display("unexpected at %0t: no sample pulse", $time);
      give_verdict();
   endtask : wait_rise_a
   task automatic t_reset();
      chk({15'h0, win}, 16'h0001);
      chk({15'h0, pin_oe}, 16'h0001);
      chk({14'h0, dac_sel}, 16'h0000);
      rd(IDX_LINE_INTERVAL, d);
      chk(d, LINE_INTERVAL_COUNT_RST);
      rd(IDX_MODE_FIRST, d);
      chk(d, 16'h0000);
      rd(10'h3ff, d);
      chk(d, 16'h0000);
   endtask : t_reset
   task automatic t_window();
      wr(IDX_LINE_INTERVAL, 16'h000f);
      wr(IDX_WIN_ENABLE, 16'h0002);
      wr(IDX_WIN_BEGIN, 16'h0002);
      wr(IDX_WIN_FINISH, 16'h0005);
      rd(IDX_WIN_FINISH, d);
      chk(d, 16'h0005);
      cnt(3, 40, c);
      cnt(2, 16, c);
      chk(16'(c), 16'h0003);
      cnt(3, 32, c);
      chk(16'(c), 16'h0002);
   endtask : t_window
   task automatic t_clamp();
      wait_rise_a();
      cnt(0, 12, c);
      chk(16'(c), 16'h0002);
      cnt(1, 16, c);
      chk(16'(c), 16'h0002);
      wr(IDX_SAMPLING, 16'h0010);
      wr(IDX_CLAMP_END, 16'h0003);
      wait_rise_a();
      cnt(0, 12, c);
      chk(16'(c), 16'h0003);
   endtask : t_clamp
   task automatic t_modes();
      wr(IDX_SAMPLING, 16'h000f);
      wr(IDX_MODE_FIRST, 16'h000e);
      wr(IDX_MODE_SECOND, 16'h0001);
      chk({12'h0, sh_en}, 16'h0001);
      chk({12'h0, gnd_sel}, 16'h0002);
      cnt(4, 32, c);
      chk(16'(c), 16'h0000);
      rd(IDX_STATUS, d);
      chk(d & 16'h001e, 16'h0008);
      wr(IDX_SAMPLING, 16'h0000);
      wr(IDX_MODE_FIRST, 16'h0000);
      cnt(4, 32, c);
      chk({15'h0, c > 0 && c <= 32}, 16'h0001);
   endtask : t_modes
   task automatic t_line();
      wr(IDX_WIN_ENABLE, 16'h0000);
      cnt(5, 16, c);
      chk(16'(c), 16'h0004);
      cnt(6, 16, c);
      chk(16'(c), 16'h0004);
      // begin equal to finish keeps the window shut for the whole line
      wr(IDX_WIN_BEGIN, 16'h0005);
      wr(IDX_WIN_ENABLE, 16'h0002);
      cnt(5, 32, c);
      chk(16'(c), 16'h0000);
      cnt(6, 16, c);
      chk(16'(c), 16'h0002);
      rd(IDX_STATUS, d);
      chk(d & 16'h001f, 16'h0000);
   endtask : t_line
   task automatic t_pin();
      wr(IDX_SAMPLING, 16'h0200);
      wr(IDX_LEVEL, 16'h0002);
      cnt(4, 6, c);
      chk({15'h0, pin_oe}, 16'h0000);
      chk({15'h0, pin_out}, 16'h0000);
      chk({8'h0, lvl_sel}, 16'h0002);
      chk({14'h0, dac_sel}, 16'h0002);
      rd(IDX_STATUS, d);
      chk(d & 16'h0020, 16'h0020);
   endtask : t_pin
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_window();
      t_clamp();
      t_modes();
      t_line();
      t_pin();
      give_verdict();
   end
endmodule : icc_top_tb
`default_nettype wire
